// [display_ctrl_consts.vh]
`ifndef DISPLAY_CTRL_CONSTS_VH
`define DISPLAY_CTRL_CONSTS_VH

// Byte addresses
`define ADDR_STATUS      8'h00
`define ADDR_WIDTH_LO    8'h01
`define ADDR_WIDTH_HI    8'h02
`define ADDR_HEIGHT_LO   8'h03
`define ADDR_HEIGHT_HI   8'h04
`define ADDR_PCLK_LO     8'h05
`define ADDR_PCLK_HI     8'h06
`define ADDR_ANALOG_FMT  8'h07
`define ADDR_DIGITAL_STD 8'h08
`define ADDR_BRIGHT      8'h09
`define ADDR_STEPS       8'h0A
`define ADDR_STEP_UP     8'h0B
`define ADDR_STEP_DOWN   8'h0C
`define ADDR_LUM_CEIL    8'h0D
`define ADDR_GAMMA_LO    8'h0E
`define ADDR_GAMMA_HI    8'h0F
`define ADDR_HUE_MODE    8'h10
`define ADDR_HOFS_LO     8'h11
`define ADDR_HOFS_HI     8'h12
`define ADDR_VOFS_LO     8'h13
`define ADDR_VOFS_HI     8'h14
`define ADDR_COL_SCAN    8'h15
`define ADDR_ROW_SCAN    8'h16
`define ADDR_PWM_DUTY    8'h17
`define ADDR_PATTERN     8'h18
`define ADDR_RGAIN_LO    8'h19
`define ADDR_RGAIN_HI    8'h1A
`define ADDR_GGAIN_LO    8'h1B
`define ADDR_GGAIN_HI    8'h1C
`define ADDR_BGAIN_LO    8'h1D
`define ADDR_BGAIN_HI    8'h1E
`define ADDR_FWREV_LO    8'h1F
`define ADDR_FWREV_HI    8'h20
`define ADDR_POWER       8'h21
`define ADDR_LED_EN      8'h22
`define ADDR_PANEL_TYPE  8'h23
`define ADDR_TEMP_LO     8'h24
`define ADDR_TEMP_HI     8'h25

// Status register field positions
`define STAT_LOCK_BIT    7
`define STAT_STD_HI      5
`define STAT_STD_LO      4
`define STAT_SRC_HI      1
`define STAT_SRC_LO      0

// Command values and limits
`define CMD_GO           8'h01
`define HUE_MODE_MAX     8'h04
`define PATTERN_MAX      8'h08

// Reset values
`define RST_ANALOG_FMT   8'h00
`define RST_DIGITAL_STD  8'h00
`define RST_BRIGHT       8'h08
`define RST_STEPS        8'h10
`define RST_LUM_CEIL     8'h64
`define RST_GAMMA        16'h0150
`define RST_HUE_MODE     8'h04
`define RST_OFFSET       16'h0000
`define RST_SCAN         8'h00
`define RST_PWM_DUTY     8'h64
`define RST_PATTERN      8'h00
`define RST_GAIN         16'h0100
`define RST_POWER        8'h01
`define RST_LED_EN       8'h01
`define RST_ZERO8        8'h00

`endif

// [display_driver_control_registers.v]
// Summary of operation
// R01 - Status bit 7 reports decoder lock
// R02 - Status bits 5:4 report detected standard
// R03 - Status bits 1:0 report active source
// R04 - Read-only active width and height values
// R05 - Read-only pixel clock frequency, fixed point
// R06 - Analog format byte: composite or separated
// R07 - Digital standard byte: NTSC or PAL
// R08 - Brightness stays within zero to step count
// R09 - Step count sets brightness range
// R10 - Writing one steps brightness up, saturating
// R11 - Writing one steps brightness down, saturating
// R12 - Luminance ceiling percentage at top step
// R13 - Two-byte fixed-point gamma exponent
// R14 - Hue mode selects values zero to four
// R15 - Signed horizontal and vertical image offsets
// R16 - Column scan order normal or reversed
// R17 - Pattern byte selects video or pattern
// R18 - Three sixteen-bit channel gains over 256
// R19 - Power byte commands; read shows actual state
// R20 - Indicator light enable, nonzero enables
// R21 - Panel type: color or monochrome green
// R22 - Read-only temperature and firmware revision
// R23 - Fixed point: fraction low, integer high
// R24 - Two-byte integers: low byte at low address
// R25 - Host uses one two-byte transfer, low first
// R26 - Row scan order normal or reversed
// R27 - Reserved status bits read zero
`timescale 1ns/1ps
`include "display_ctrl_consts.vh"

module display_driver_control_registers
#(
   parameter [7:0]  PANEL_TYPE_RESET = 8'h00,
   parameter [15:0] FW_REVISION      = 16'h0100  // Arbitrary value
)
(
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst,
   // Byte register port from the serial target
   input  wire [7:0]  regAddr,
   input  wire        regWrEn,
   input  wire [7:0]  regWrData,
   input  wire        regRdEn,
   output reg  [7:0]  regRdData_q,
   output reg         regRdValid_q,
   // Video status from the pipeline, same clock
   input  wire        decoderLocked,
   input  wire [1:0]  stdDefDetectStatus,
   input  wire [1:0]  inputSource,
   input  wire [15:0] inputActiveWidth,
   input  wire [15:0] inputActiveHeight,
   input  wire [15:0] inputPixelClockFreq,
   input  wire [15:0] panelTemperature,
   input  wire        poweredUp,
   // Control values to the pipeline
   output reg  [7:0]  analogInputFormat_q,
   output reg  [7:0]  digitalInputStandard_q,
   output reg  [7:0]  brightnessLevel_q,
   output reg  [7:0]  brightnessStepCount_q,
   output reg  [7:0]  luminanceCeilingPct_q,
   output reg  [15:0] toneCurveExponent_q,
   output reg  [7:0]  hueModeSelect_q,
   output reg  [15:0] horizontalImageOffset_q,
   output reg  [15:0] verticalImageOffset_q,
   output reg  [7:0]  columnScanOrder_q,
   output reg  [7:0]  rowScanOrder_q,
   output reg  [7:0]  framePwmDuty_q,
   output reg  [7:0]  testPatternSelect_q,
   output reg  [15:0] redChannelGain_q,
   output reg  [15:0] greenChannelGain_q,
   output reg  [15:0] blueChannelGain_q,
   output reg  [7:0]  powerStateCtrl_q,
   output reg  [7:0]  indicatorLightEnable_q,
   output reg  [7:0]  panelTypeSelect_q
);

   // Low byte of a two-byte write waits here until its high byte arrives
   reg  [7:0]  wrLowHold_q;
   // High byte captured when the low byte is read, so a pair reads coherent
   reg  [7:0]  rdHighHold_q;
   reg  [7:0]  brightnessLevel_d;
   reg  [7:0]  rdByte;
   reg  [7:0]  rdHigh;
   reg  [7:0]  statusByte;
   wire        wr;

   assign wr = regWrEn;

   // Reserved bits read zero, so a host that masks them loses nothing
   always @*
   begin
      statusByte                            = `RST_ZERO8;            // R27
      statusByte[`STAT_LOCK_BIT]            = decoderLocked;         // R01
      statusByte[`STAT_STD_HI:`STAT_STD_LO] = stdDefDetectStatus;    // R02
      statusByte[`STAT_SRC_HI:`STAT_SRC_LO] = inputSource;           // R03
   end

   // Brightness next value; a new step count also pulls brightness down
   always @*
   begin
      brightnessLevel_d = brightnessLevel_q;
      if (wr && regAddr == `ADDR_BRIGHT)
      begin
         if (regWrData > brightnessStepCount_q)                      // R08
            brightnessLevel_d = brightnessStepCount_q;
         else
            brightnessLevel_d = regWrData;
      end
      else if (wr && regAddr == `ADDR_STEPS)
      begin
         if (brightnessLevel_q > regWrData)                          // R09
            brightnessLevel_d = regWrData;
      end
      else if (wr && regAddr == `ADDR_STEP_UP && regWrData == `CMD_GO)
      begin
         if (brightnessLevel_q != brightnessStepCount_q)             // R10
            brightnessLevel_d = brightnessLevel_q + 8'h01;
      end
      else if (wr && regAddr == `ADDR_STEP_DOWN && regWrData == `CMD_GO)
      begin
         if (brightnessLevel_q != `RST_ZERO8)                        // R11
            brightnessLevel_d = brightnessLevel_q - 8'h01;
      end
   end

   // Brightness register; the clamp logic above picks its next value
   always @(posedge core_clk)
   begin
      if (rst)
         brightnessLevel_q <= `RST_BRIGHT;
      else
         brightnessLevel_q <= brightnessLevel_d;
   end

   // Input format selections
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         analogInputFormat_q    <= `RST_ANALOG_FMT;
         digitalInputStandard_q <= `RST_DIGITAL_STD;
      end
      else if (wr)
      begin
         case (regAddr)
            `ADDR_ANALOG_FMT:  analogInputFormat_q    <= regWrData;   // R06
            `ADDR_DIGITAL_STD: digitalInputStandard_q <= regWrData;   // R07
            default:           analogInputFormat_q    <= analogInputFormat_q;
         endcase
      end
   end

   // Step count and luminance limits
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         brightnessStepCount_q <= `RST_STEPS;
         luminanceCeilingPct_q <= `RST_LUM_CEIL;
         framePwmDuty_q        <= `RST_PWM_DUTY;
      end
      else if (wr)
      begin
         case (regAddr)
            `ADDR_STEPS:    brightnessStepCount_q <= regWrData;   // R09
            `ADDR_LUM_CEIL: luminanceCeilingPct_q <= regWrData;   // R12
            `ADDR_PWM_DUTY: framePwmDuty_q        <= regWrData;
            default:        framePwmDuty_q        <= framePwmDuty_q;
         endcase
      end
   end

   // Scan order
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         columnScanOrder_q <= `RST_SCAN;
         rowScanOrder_q    <= `RST_SCAN;
      end
      else if (wr)
      begin
         case (regAddr)
            `ADDR_COL_SCAN: columnScanOrder_q <= regWrData;   // R16
            `ADDR_ROW_SCAN: rowScanOrder_q    <= regWrData;   // R26
            default:        rowScanOrder_q    <= rowScanOrder_q;
         endcase
      end
   end

   // System controls; the power byte is only a command here
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         powerStateCtrl_q       <= `RST_POWER;
         indicatorLightEnable_q <= `RST_LED_EN;
         panelTypeSelect_q      <= PANEL_TYPE_RESET;
      end
      else if (wr)
      begin
         case (regAddr)
            `ADDR_POWER:      powerStateCtrl_q       <= regWrData;   // R19
            `ADDR_LED_EN:     indicatorLightEnable_q <= regWrData;   // R20
            `ADDR_PANEL_TYPE: panelTypeSelect_q      <= regWrData;   // R21
            default:          powerStateCtrl_q       <= powerStateCtrl_q;
         endcase
      end
   end

   // Out-of-range selections are refused rather than stored
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         hueModeSelect_q     <= `RST_HUE_MODE;
         testPatternSelect_q <= `RST_PATTERN;
      end
      else if (wr)
      begin
         if (regAddr == `ADDR_HUE_MODE && regWrData <= `HUE_MODE_MAX)   // R14
            hueModeSelect_q <= regWrData;
         if (regAddr == `ADDR_PATTERN && regWrData <= `PATTERN_MAX)     // R17
            testPatternSelect_q <= regWrData;
      end
   end

   // One shared hold for all low bytes; a lone high write reuses it
   always @(posedge core_clk)
   begin
      if (rst)
         wrLowHold_q <= `RST_ZERO8;
      else if (wr)
      begin
         case (regAddr)
            `ADDR_GAMMA_LO,
            `ADDR_HOFS_LO,
            `ADDR_VOFS_LO,
            `ADDR_RGAIN_LO,
            `ADDR_GGAIN_LO,
            `ADDR_BGAIN_LO: wrLowHold_q <= regWrData;   // R25
            default:        wrLowHold_q <= wrLowHold_q;
         endcase
      end
   end

   // High byte commits the pair at once, so no half value is ever seen
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         toneCurveExponent_q     <= `RST_GAMMA;
         horizontalImageOffset_q <= `RST_OFFSET;
         verticalImageOffset_q   <= `RST_OFFSET;
      end
      else if (wr)
      begin
         case (regAddr)
            `ADDR_GAMMA_HI: toneCurveExponent_q     <= {regWrData, wrLowHold_q};   // R13
            `ADDR_HOFS_HI:  horizontalImageOffset_q <= {regWrData, wrLowHold_q};   // R15
            `ADDR_VOFS_HI:  verticalImageOffset_q   <= {regWrData, wrLowHold_q};   // R15
            default:        toneCurveExponent_q     <= toneCurveExponent_q;
         endcase
      end
   end

   // Channel gains, same pair commit
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         redChannelGain_q   <= `RST_GAIN;
         greenChannelGain_q <= `RST_GAIN;
         blueChannelGain_q  <= `RST_GAIN;
      end
      else if (wr)
      begin
         case (regAddr)
            `ADDR_RGAIN_HI: redChannelGain_q   <= {regWrData, wrLowHold_q};   // R18
            `ADDR_GGAIN_HI: greenChannelGain_q <= {regWrData, wrLowHold_q};   // R18
            `ADDR_BGAIN_HI: blueChannelGain_q  <= {regWrData, wrLowHold_q};   // R24
            default:        redChannelGain_q   <= redChannelGain_q;
         endcase
      end
   end

   // Read mux; low-address byte first, read-only high bytes taken from the snapshot, writable high bytes read live
   always @*
   begin
      rdByte = `RST_ZERO8;
      rdHigh = rdHighHold_q;
      case (regAddr)
         `ADDR_STATUS:      rdByte = statusByte;
         `ADDR_WIDTH_LO:
         begin
            rdByte = inputActiveWidth[7:0];                              // R04
            rdHigh = inputActiveWidth[15:8];
         end
         `ADDR_HEIGHT_LO:
         begin
            rdByte = inputActiveHeight[7:0];                             // R04
            rdHigh = inputActiveHeight[15:8];
         end
         `ADDR_PCLK_LO:
         begin
            rdByte = inputPixelClockFreq[7:0];                           // R05
            rdHigh = inputPixelClockFreq[15:8];                          // R23
         end
         `ADDR_FWREV_LO:
         begin
            rdByte = FW_REVISION[7:0];                                   // R22
            rdHigh = FW_REVISION[15:8];
         end
         `ADDR_TEMP_LO:
         begin
            rdByte = panelTemperature[7:0];                              // R22
            rdHigh = panelTemperature[15:8];
         end
         `ADDR_WIDTH_HI,
         `ADDR_HEIGHT_HI,
         `ADDR_PCLK_HI,
         `ADDR_FWREV_HI,
         `ADDR_TEMP_HI:     rdByte = rdHighHold_q;
         `ADDR_ANALOG_FMT:  rdByte = analogInputFormat_q;
         `ADDR_DIGITAL_STD: rdByte = digitalInputStandard_q;
         `ADDR_BRIGHT:      rdByte = brightnessLevel_q;
         `ADDR_STEPS:       rdByte = brightnessStepCount_q;
         `ADDR_LUM_CEIL:    rdByte = luminanceCeilingPct_q;
         `ADDR_GAMMA_LO:    rdByte = toneCurveExponent_q[7:0];
         `ADDR_GAMMA_HI:    rdByte = toneCurveExponent_q[15:8];
         `ADDR_HUE_MODE:    rdByte = hueModeSelect_q;
         `ADDR_HOFS_LO:     rdByte = horizontalImageOffset_q[7:0];
         `ADDR_HOFS_HI:     rdByte = horizontalImageOffset_q[15:8];
         `ADDR_VOFS_LO:     rdByte = verticalImageOffset_q[7:0];
         `ADDR_VOFS_HI:     rdByte = verticalImageOffset_q[15:8];
         `ADDR_COL_SCAN:    rdByte = columnScanOrder_q;
         `ADDR_ROW_SCAN:    rdByte = rowScanOrder_q;
         `ADDR_PWM_DUTY:    rdByte = framePwmDuty_q;
         `ADDR_PATTERN:     rdByte = testPatternSelect_q;
         `ADDR_RGAIN_LO:    rdByte = redChannelGain_q[7:0];
         `ADDR_RGAIN_HI:    rdByte = redChannelGain_q[15:8];
         `ADDR_GGAIN_LO:    rdByte = greenChannelGain_q[7:0];
         `ADDR_GGAIN_HI:    rdByte = greenChannelGain_q[15:8];
         `ADDR_BGAIN_LO:    rdByte = blueChannelGain_q[7:0];
         `ADDR_BGAIN_HI:    rdByte = blueChannelGain_q[15:8];
         // Shows the real state, not the last command
         `ADDR_POWER:       rdByte = {7'b0000000, poweredUp};           // R19
         `ADDR_LED_EN:      rdByte = indicatorLightEnable_q;
         `ADDR_PANEL_TYPE:  rdByte = panelTypeSelect_q;
         default:           rdByte = `RST_ZERO8;
      endcase
   end

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         regRdData_q  <= `RST_ZERO8;
         regRdValid_q <= 1'b0;
         rdHighHold_q <= `RST_ZERO8;
      end
      else
      begin
         regRdValid_q <= regRdEn;
         if (regRdEn)
         begin
            regRdData_q  <= rdByte;
            rdHighHold_q <= rdHigh;
         end
      end
   end

endmodule

// [display_ctrl_assertions.sv]
`timescale 1ns/1ps
module display_ctrl_checker
(
   // Clock and reset
   input wire       core_clk,
   input wire       rst,
   // Byte register port
   input wire [7:0] regAddr,
   input wire       regWrEn,
   input wire [7:0] regWrData,
   input wire       regRdEn,
   input wire [7:0] regRdData_q,
   input wire       regRdValid_q,
   // Status and controls
   input wire       decoderLocked,
   input wire [1:0] stdDefDetectStatus,
   input wire [1:0] inputSource,
   input wire [7:0] brightnessLevel_q,
   input wire [7:0] brightnessStepCount_q,
   input wire [7:0] hueModeSelect_q,
   input wire [7:0] testPatternSelect_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   wire [7:0] lvl = brightnessLevel_q;
   wire [7:0] stp = brightnessStepCount_q;
   wire       upCmd = regWrEn && regAddr == 8'h0B && regWrData == 8'h01;
   wire       dnCmd = regWrEn && regAddr == 8'h0C && regWrData == 8'h01;
   read_answer_a: assert property (regRdEn |=> regRdValid_q)
      else $error("read strobe without answer");
   read_quiet_a: assert property (!regRdEn |=> !regRdValid_q)
      else $error("answer without read strobe");
   status_bits_a: assert property (
      regRdEn && regAddr == 8'h00 |=> regRdData_q == {$past(decoderLocked), 1'b0,
      $past(stdDefDetectStatus), 2'b00, $past(inputSource)})
      else $error("status byte wrong");
   step_up_a: assert property (upCmd && lvl < stp |=> lvl == $past(lvl) + 8'h01)
      else $error("step up did not add one");
   up_limit_a: assert property (upCmd && lvl == stp |=> $stable(lvl))
      else $error("step up passed the step count");
   step_down_a: assert property (dnCmd && lvl != 8'h00 |=> lvl == $past(lvl) - 8'h01)
      else $error("step down did not subtract one");
   down_floor_a: assert property (dnCmd && lvl == 8'h00 |=> lvl == 8'h00)
      else $error("step down went below zero");
   bright_range_a: assert property (lvl <= stp)
      else $error("brightness above step count");
   bright_write_a: assert property (
      regWrEn && regAddr == 8'h09 && regWrData <= stp |=> lvl == $past(regWrData))
      else $error("legal brightness write lost");
   hue_refuse_a: assert property (
      regWrEn && regAddr == 8'h10 && regWrData > 8'h04 |=> $stable(hueModeSelect_q))
      else $error("hue mode took an illegal value");
   pattern_refuse_a: assert property (
      regWrEn && regAddr == 8'h18 && regWrData > 8'h08 |=> $stable(testPatternSelect_q))
      else $error("pattern took an illegal value");
endmodule

bind display_driver_control_registers display_ctrl_checker display_ctrl_checker_i (
   .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
   .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
   .regRdValid_q(regRdValid_q), .decoderLocked(decoderLocked),
   .stdDefDetectStatus(stdDefDetectStatus), .inputSource(inputSource),
   .brightnessLevel_q(brightnessLevel_q), .brightnessStepCount_q(brightnessStepCount_q),
   .hueModeSelect_q(hueModeSelect_q), .testPatternSelect_q(testPatternSelect_q)
);

// [host_model.sv]
`timescale 1ns/1ps
module host_model
(
   // Clock
   input  wire        core_clk,
   // Byte register port
   output logic [7:0] regAddr = 8'h00,
   output logic       regWrEn = 1'b0,
   output logic [7:0] regWrData = 8'h00,
   output logic       regRdEn = 1'b0
);
   task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      regAddr = a;
      regWrData = d;
      regWrEn = w;
      regRdEn = ~w;
   endtask
   // Released lines flip so a stale value never looks valid
   task automatic idle();
      @(negedge core_clk);
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = ~regAddr;
      regWrData = ~regWrData;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      put(1'b1, a, d);
      idle();
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      put(1'b1, a, v[7:0]);
      put(1'b1, a + 8'h01, v[15:8]);
      idle();
   endtask
   task automatic rd(input logic [7:0] a);
      put(1'b0, a, regWrData);
      idle();
   endtask
   task automatic rd16(input logic [7:0] a);
      put(1'b0, a, regWrData);
      put(1'b0, a + 8'h01, regWrData);
      idle();
   endtask
endmodule

// [display_driver_control_registers_test.sv]
`timescale 1ns/1ps
module test_display_driver_control_registers;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  regAddr, regWrData, regRdData_q, lvl, hue, pat, pwr, stp, lum, pwm;
   logic        regWrEn, regRdEn, regRdValid_q;
   logic        decoderLocked = 1'b0, poweredUp = 1'b1;
   logic [1:0]  stdDefDetectStatus = 2'h0, inputSource = 2'h0;
   logic [15:0] inputActiveWidth = 16'h0000, inputActiveHeight = 16'h0000;
   logic [15:0] inputPixelClockFreq = 16'h0000, panelTemperature = 16'h0000;
   logic [15:0] v;
   wire  [47:0] bOut;
   wire  [95:0] wOut;
   logic [7:0]  expQ [$];
   int          err_total = 0, check_count = 0, cycles = 0, i;
   logic [15:0] rstTab [0:20] = '{16'h0700, 16'h0800, 16'h0908, 16'h0A10, 16'h0D64,
      16'h0E50, 16'h0F01, 16'h1004, 16'h1100, 16'h1300, 16'h1500, 16'h1600, 16'h1764,
      16'h1800, 16'h1900, 16'h1A01, 16'h2201, 16'h2300, 16'h0B00, 16'h3000, 16'h2101};
   logic [7:0]  roAddr [0:3] = '{8'h01, 8'h03, 8'h05, 8'h24};
   logic [7:0]  rwAddr [0:5] = '{8'h0E, 8'h11, 8'h13, 8'h19, 8'h1B, 8'h1D};
   logic [7:0]  bAddr [0:5] = '{8'h07, 8'h08, 8'h15, 8'h16, 8'h22, 8'h23};
   always #10 core_clk = ~core_clk;
   host_model host_model_i (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn));
   display_driver_control_registers display_driver_control_registers_i (
      .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
      .regRdValid_q(regRdValid_q), .decoderLocked(decoderLocked),
      .stdDefDetectStatus(stdDefDetectStatus), .inputSource(inputSource),
      .inputActiveWidth(inputActiveWidth), .inputActiveHeight(inputActiveHeight),
      .inputPixelClockFreq(inputPixelClockFreq), .panelTemperature(panelTemperature),
      .poweredUp(poweredUp), .analogInputFormat_q(bOut[7:0]),
      .digitalInputStandard_q(bOut[15:8]), .brightnessLevel_q(lvl),
      .brightnessStepCount_q(stp), .luminanceCeilingPct_q(lum),
      .toneCurveExponent_q(wOut[15:0]), .hueModeSelect_q(hue),
      .horizontalImageOffset_q(wOut[31:16]), .verticalImageOffset_q(wOut[47:32]),
      .columnScanOrder_q(bOut[23:16]), .rowScanOrder_q(bOut[31:24]),
      .framePwmDuty_q(pwm), .testPatternSelect_q(pat), .redChannelGain_q(wOut[63:48]),
      .greenChannelGain_q(wOut[79:64]), .blueChannelGain_q(wOut[95:80]),
      .powerStateCtrl_q(pwr), .indicatorLightEnable_q(bOut[39:32]),
      .panelTypeSelect_q(bOut[47:40]));
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      host_model_i.rd(a);
   endtask
   task automatic rc16(input logic [7:0] a, input logic [15:0] e);
      expQ.push_back(e[7:0]);
      expQ.push_back(e[15:8]);
      host_model_i.rd16(a);
   endtask
   task automatic final_report();
      // Notes still queued mean reads that were never answered
      if (expQ.size() != 0)
         chk(16'(expQ.size()), 16'h0000);
      $display("Comparisons %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Answers are matched in order; an answer with no note is a mismatch too
   always @(negedge core_clk)
   begin
      if (regRdValid_q === 1'b1)
         chk({8'h00, regRdData_q}, expQ.size() ? {8'h00, expQ.pop_front()} : 16'h0100);
   end
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_total++;
         final_report();
      end
   end
   initial
   begin
      void'($urandom(32'h609B2F4A));
      repeat (4) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      chk({8'h00, pwm}, 16'h0064);
      for (i = 0; i < 21; i++)
         rc(rstTab[i][15:8], rstTab[i][7:0]);
      repeat (8)
      begin
         @(negedge core_clk) v = $urandom;
         {decoderLocked, stdDefDetectStatus, inputSource} = v[4:0];
         rc(8'h00, {decoderLocked, 1'b0, stdDefDetectStatus, 2'b00, inputSource});
      end
      for (i = 0; i < 4; i++)
      begin
         @(negedge core_clk) v = $urandom;
         inputActiveWidth = v;
         inputActiveHeight = ~v;
         inputPixelClockFreq = v ^ 16'h5A5A;
         panelTemperature = v + 16'h0001;
         rc16(roAddr[i], i == 0 ? v : i == 1 ? ~v : i == 2 ? v ^ 16'h5A5A : v + 16'h0001);
      end
      rc16(8'h1F, 16'h0100);
      for (i = 0; i < 6; i++)
      begin
         v = $urandom;
         host_model_i.wr16(rwAddr[i], v);
         chk(wOut[16*i +: 16], v);
         rc16(rwAddr[i], v);
      end
      host_model_i.wr16(8'h19, 16'h0080);
      chk(wOut[63:48], 16'h0080);
      for (i = 0; i < 6; i++)
      begin
         v = $urandom;
         host_model_i.wr(bAddr[i], {7'h00, v[0]});
         chk({8'h00, bOut[8*i +: 8]}, {15'h0000, v[0]});
         rc(bAddr[i], {7'h00, v[0]});
      end
      host_model_i.wr(8'h21, 8'h00);
      chk({8'h00, pwr}, 16'h0000);
      rc(8'h21, 8'h01);
      @(negedge core_clk) poweredUp = 1'b0;
      rc(8'h21, 8'h00);
      host_model_i.wr(8'h0A, 8'h04);
      host_model_i.wr(8'h09, 8'h20);
      host_model_i.wr(8'h0B, 8'h01);
      chk({8'h00, lvl}, 16'h0004);
      for (i = 0; i < 5; i++)
      begin
         host_model_i.wr(8'h0C, 8'h01);
         chk({8'h00, lvl}, i < 4 ? 16'(3 - i) : 16'h0000);
      end
      host_model_i.wr(8'h0B, 8'h02);
      chk({8'h00, lvl}, 16'h0000);
      host_model_i.wr(8'h0B, 8'h01);
      chk({8'h00, lvl}, 16'h0001);
      host_model_i.wr(8'h09, 8'h02);
      rc(8'h09, 8'h02);
      host_model_i.wr(8'h0A, 8'h20);
      rc(8'h0A, 8'h20);
      chk({8'h00, stp}, 16'h0020);
      host_model_i.wr(8'h0D, 8'h32);
      rc(8'h0D, 8'h32);
      chk({8'h00, lum}, 16'h0032);
      for (i = 0; i < 6; i++)
      begin
         host_model_i.wr(8'h10, 8'(i));
         chk({8'h00, hue}, i < 5 ? 16'(i) : 16'h0004);
      end
      for (i = 0; i < 10; i++)
      begin
         host_model_i.wr(8'h18, 8'(i));
         chk({8'h00, pat}, i < 9 ? 16'(i) : 16'h0008);
      end
      repeat (3) @(negedge core_clk);
      final_report();
   end
endmodule
